// *** design/frame_pkg.sv ***
// package: frame layout constants, status codes and shared types
package frame_pkg;
  // ****************************************
  // frame framing
  // ****************************************
  localparam logic [7:0] START_DELIM = 8'h7e;
  localparam logic [7:0] CSUM_BASE = 8'hff;
  localparam int TYPE_OFS = 3;
  localparam int ID_OFS = 4;
  localparam logic [4:0] HDR_BYTES = 5'h03; // start plus two length bytes
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  localparam int PARAM_MAX = 8;
  // ****************************************
  // frame types
  // ****************************************
  localparam logic [7:0] TYPE_REMOTE_RSP = 8'h87;
  localparam logic [7:0] TYPE_LOCAL_RSP = 8'h88;
  localparam logic [7:0] TYPE_TX_STATUS = 8'h89;
  // ****************************************
  // field offsets
  // ****************************************
  localparam int REM_ADDR_OFS = 5;
  localparam int REM_CMD_OFS = 13;
  localparam int REM_STATUS_OFS = 15;
  localparam int LOC_CMD_OFS = 5;
  localparam int LOC_STATUS_OFS = 7;
  localparam int TXS_STATUS_OFS = 5;
  localparam logic [4:0] REM_FIXED_END = 5'h10; // first offset after remote status
  localparam logic [4:0] LOC_FIXED_END = 5'h08;
  localparam logic [4:0] TXS_FIXED_END = 5'h06;
  localparam logic [7:0] TX_ID_SUPPRESS = 8'h00;
  // ****************************************
  // command status codes
  // ****************************************
  localparam logic [7:0] CMD_OK = 8'h00;
  localparam logic [7:0] CMD_ERROR = 8'h01;
  localparam logic [7:0] CMD_UNKNOWN = 8'h02;
  localparam logic [7:0] CMD_BAD_PARAM = 8'h03;
  localparam logic [7:0] CMD_TX_FAIL = 8'h04;
  // ****************************************
  // transmit status codes
  // ****************************************
  localparam logic [7:0] TXS_SUCCESS = 8'h00;
  localparam logic [7:0] TXS_PURGED = 8'h03;
  localparam logic [7:0] TXS_PHY_ERR = 8'h04;
  localparam logic [7:0] TXS_NO_ACK = 8'h21;
  localparam logic [7:0] TXS_RESOURCE = 8'h32;
  localparam logic [7:0] TXS_TOO_LONG = 8'h74;
  localparam logic [7:0] TXS_SOCKET_FAIL = 8'h76;
  localparam logic [7:0] TXS_NO_SESSION = 8'h77;
  localparam logic [7:0] TXS_NO_LISTENER = 8'h78;

  typedef enum logic [1:0] {KIND_REMOTE, KIND_LOCAL, KIND_TXSTAT} frame_kind_t;
endpackage

// *** design/byte_stream_if.sv ***
// interface: valid/ready byte stream between framer and fifo
`timescale 1ns/1ps
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// *** design/byte_fifo.sv ***
// module: flop-based fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // fill side
  byte_stream_if.dst wr,
  // drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // handshakes: full and empty straight from the count
  // the count is one bit wider than the pointers, so full must be compared at that width
  assign wr.ready = (cnt_r != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign rd_valid = (cnt_r != '0);
  assign rd_data = mem_r[rp_r];
  assign push = wr.valid && wr.ready;
  assign pop = rd_valid && rd_ready;

  // next pointers and storage
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = (push && wp_r == AW'(i)) ? wr.data : mem_r[i];
    end
  end

  // registers; storage needs no reset
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (ce) begin
      mem_r <= mem_nxt;
    end
  end
endmodule

// *** design/api_response_frame_builder.sv ***
// module: builds remote, local and transmit-status response frames
`timescale 1ns/1ps
// Overview of operation
// - remote command response frame carries type 0x87 at offset 3.
// - frame id at offset 4, eight-byte responder address at 5-12, ip low.
// - two ascii command characters at offsets 13 and 14.
// - remote status at 15: ok, error, unknown, bad parameter, tx failure.
// - remote parameter value follows status only for a query.
// - local command response frame carries type 0x88 at offset 3.
// - some commands like network scan produce several local responses.
// - local frame: id at 4, command at 5-6, status at 7.
// - local value follows status, omitted when host wrote a setting.
// - transmit status frame carries type 0x89 at offset 3.
// - copy host frame id to offset 4; id zero suppresses the frame.
// - tx status 0x00 success, 0x03 purged, 0x04 physical fault.
// - tx status 0x21 no ack, 0x32 resources, 0x74 too long.
// - tx status 0x76 socket fail, 0x77 no session, 0x78 no listener.
module api_response_frame_builder (
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // frame request
  input wire logic req_valid,
  output logic req_ready,
  input wire frame_pkg::frame_kind_t req_kind,
  input wire logic [7:0] req_frame_id,
  input wire logic [31:0] req_ip_addr,
  input wire logic [15:0] req_command,
  input wire logic [7:0] req_status,
  input wire logic [3:0] req_param_len,
  input wire logic [63:0] req_param,
  // serial byte stream out
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  // status
  output logic busy,
  output logic suppressed
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_EMIT, ST_CSUM} build_state_t;
  build_state_t st_r, st_nxt;
  frame_pkg::frame_kind_t kind_r, kind_nxt;
  logic [7:0] id_r, id_nxt;
  logic [31:0] ip_r, ip_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [3:0] plen_r, plen_nxt;
  logic [63:0] par_r, par_nxt;
  logic [4:0] ofs_r, ofs_nxt;
  logic [7:0] sum_r, sum_nxt;
  logic supp_r, supp_nxt;
  logic [4:0] fixed_end, last_ofs;
  logic [7:0] data_len, cur_byte;
  logic [3:0] pidx;
  byte_stream_if fifo_in ();

  // ****************************************
  // frame geometry
  // ****************************************
  // fixed part ends where each kind's status byte stops
  always_comb begin
    case (kind_r)
      frame_pkg::KIND_REMOTE: fixed_end = frame_pkg::REM_FIXED_END;
      frame_pkg::KIND_LOCAL: fixed_end = frame_pkg::LOC_FIXED_END;
      default: fixed_end = frame_pkg::TXS_FIXED_END;
    endcase
    // transmit status never carries a value
    last_ofs = fixed_end + ((kind_r == frame_pkg::KIND_TXSTAT) ? 5'h00 : {1'b0, plen_r});
    data_len = 8'(last_ofs - frame_pkg::HDR_BYTES);
    pidx = 4'(ofs_r - fixed_end);
  end

  // byte selected by offset; value bytes are sent most significant first
  always_comb begin
    cur_byte = 8'h00;
    if (ofs_r == 5'h00) begin
      cur_byte = frame_pkg::START_DELIM;
    end else if (ofs_r == 5'h01) begin
      cur_byte = 8'h00; // length high, frames stay short
    end else if (ofs_r == 5'h02) begin
      cur_byte = data_len;
    end else if (ofs_r == 5'(frame_pkg::TYPE_OFS)) begin
      case (kind_r)
        frame_pkg::KIND_REMOTE: cur_byte = frame_pkg::TYPE_REMOTE_RSP;
        frame_pkg::KIND_LOCAL: cur_byte = frame_pkg::TYPE_LOCAL_RSP;
        default: cur_byte = frame_pkg::TYPE_TX_STATUS;
      endcase
    end else if (ofs_r == 5'(frame_pkg::ID_OFS)) begin
      cur_byte = id_r;
    end else if (ofs_r >= fixed_end) begin
      cur_byte = par_r[63 - 8*(32'(pidx)) -: 8];
    end else begin
      case (kind_r)
        frame_pkg::KIND_REMOTE: begin
          if (ofs_r < 5'(frame_pkg::REM_ADDR_OFS + 4)) begin
            cur_byte = 8'h00; // upper address bytes zero
          end else if (ofs_r < 5'(frame_pkg::REM_CMD_OFS)) begin
            cur_byte = ip_r[31 - 8*(32'(ofs_r) - frame_pkg::REM_ADDR_OFS - 4) -: 8];
          end else if (ofs_r == 5'(frame_pkg::REM_CMD_OFS)) begin
            cur_byte = cmd_r[15:8];
          end else if (ofs_r == 5'(frame_pkg::REM_CMD_OFS + 1)) begin
            cur_byte = cmd_r[7:0];
          end else begin
            cur_byte = stat_r;
          end
        end
        frame_pkg::KIND_LOCAL: begin
          if (ofs_r == 5'(frame_pkg::LOC_CMD_OFS)) begin
            cur_byte = cmd_r[15:8];
          end else if (ofs_r == 5'(frame_pkg::LOC_CMD_OFS + 1)) begin
            cur_byte = cmd_r[7:0];
          end else begin
            cur_byte = stat_r;
          end
        end
        default: cur_byte = stat_r;
      endcase
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // one request per frame; a scan answer is simply several local requests
  assign req_ready = (st_r == ST_IDLE);
  assign fifo_in.valid = (st_r != ST_IDLE);
  assign fifo_in.data = (st_r == ST_CSUM) ? (frame_pkg::CSUM_BASE - sum_r) : cur_byte;
  assign busy = (st_r != ST_IDLE);
  assign suppressed = supp_r;

  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    id_nxt = id_r;
    ip_nxt = ip_r;
    cmd_nxt = cmd_r;
    stat_nxt = stat_r;
    plen_nxt = plen_r;
    par_nxt = par_r;
    ofs_nxt = ofs_r;
    sum_nxt = sum_r;
    supp_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (req_valid) begin
          if (req_kind == frame_pkg::KIND_TXSTAT && req_frame_id == frame_pkg::TX_ID_SUPPRESS) begin
            supp_nxt = 1'b1;
          end else begin
            st_nxt = ST_EMIT;
            kind_nxt = req_kind;
            id_nxt = req_frame_id;
            ip_nxt = req_ip_addr;
            cmd_nxt = req_command;
            stat_nxt = req_status;
            plen_nxt = (req_param_len > 4'(frame_pkg::PARAM_MAX)) ? 4'(frame_pkg::PARAM_MAX) : req_param_len;
            par_nxt = req_param;
            ofs_nxt = 5'h00;
            sum_nxt = 8'h00;
          end
        end
      end
      ST_EMIT: begin
        if (fifo_in.ready) begin
          if (ofs_r >= 5'(frame_pkg::TYPE_OFS)) begin
            sum_nxt = sum_r + cur_byte;
          end
          ofs_nxt = ofs_r + 5'h01;
          if (ofs_r + 5'h01 == last_ofs) begin
            st_nxt = ST_CSUM;
          end
        end
      end
      default: begin
        if (fifo_in.ready) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= ST_IDLE;
      kind_r <= frame_pkg::KIND_REMOTE;
      id_r <= 8'h00;
      ip_r <= 32'h0000_0000;
      cmd_r <= 16'h0000;
      stat_r <= 8'h00;
      plen_r <= 4'h0;
      par_r <= 64'h0;
      ofs_r <= 5'h00;
      sum_r <= 8'h00;
      supp_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      id_r <= id_nxt;
      ip_r <= ip_nxt;
      cmd_r <= cmd_nxt;
      stat_r <= stat_nxt;
      plen_r <= plen_nxt;
      par_r <= par_nxt;
      ofs_r <= ofs_nxt;
      sum_r <= sum_nxt;
      supp_r <= supp_nxt;
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  // the fifo lets the serial side stall without losing frame bytes
  byte_fifo #(.WIDTH(frame_pkg::DATA_W), .DEPTH(frame_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .wr(fifo_in.dst),
    .rd_valid(out_valid),
    .rd_ready(out_ready),
    .rd_data(out_data)
  );

  // ****************************************
  // checks
  // ****************************************
  property p_start_first;
    @(posedge clk) disable iff (srst)
      (ce && st_r == ST_IDLE && req_valid && !(req_kind == frame_pkg::KIND_TXSTAT && req_frame_id == 8'h00))
      |=> (ofs_r == 5'h00 && fifo_in.data == 8'h7e && fifo_in.valid);
  endproperty
  a_start_first: assert property (p_start_first) else $error("frame does not open with delimiter");

  property p_suppress;
    @(posedge clk) disable iff (srst)
      (ce && st_r == ST_IDLE && req_valid && req_kind == frame_pkg::KIND_TXSTAT && req_frame_id == 8'h00)
      |=> (st_r == ST_IDLE && suppressed);
  endproperty
  a_suppress: assert property (p_suppress) else $error("status frame with id zero was not suppressed");

  property p_type_remote;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && ofs_r == 5'h03 && kind_r == frame_pkg::KIND_REMOTE) |-> fifo_in.data == 8'h87;
  endproperty
  a_type_remote: assert property (p_type_remote) else $error("remote type byte wrong");

  property p_type_local;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && ofs_r == 5'h03 && kind_r == frame_pkg::KIND_LOCAL) |-> fifo_in.data == 8'h88;
  endproperty
  a_type_local: assert property (p_type_local) else $error("local type byte wrong");

  property p_type_txs;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && ofs_r == 5'h03 && kind_r == frame_pkg::KIND_TXSTAT) |-> fifo_in.data == 8'h89;
  endproperty
  a_type_txs: assert property (p_type_txs) else $error("status type byte wrong");

  property p_id_copy;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && ofs_r == 5'h04) |-> fifo_in.data == id_r;
  endproperty
  a_id_copy: assert property (p_id_copy) else $error("frame id not at offset 4");

  property p_rem_addr_hi;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && kind_r == frame_pkg::KIND_REMOTE && ofs_r >= 5'h05 && ofs_r <= 5'h08)
      |-> fifo_in.data == 8'h00;
  endproperty
  a_rem_addr_hi: assert property (p_rem_addr_hi) else $error("upper address bytes not zero");

  property p_txs_len;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && kind_r == frame_pkg::KIND_TXSTAT && ofs_r == 5'h02) |-> fifo_in.data == 8'h03;
  endproperty
  a_txs_len: assert property (p_txs_len) else $error("status frame length wrong");

  property p_csum;
    @(posedge clk) disable iff (srst)
      (st_r == ST_CSUM) |-> fifo_in.data == 8'(8'hff - sum_r);
  endproperty
  a_csum: assert property (p_csum) else $error("checksum byte wrong");

  // a status frame must close right after its status byte, whatever value length was asked for
  property p_txs_end;
    @(posedge clk) disable iff (srst)
      (ce && st_r == ST_EMIT && kind_r == frame_pkg::KIND_TXSTAT && ofs_r == 5'h05 && fifo_in.ready)
      |=> (st_r == ST_CSUM);
  endproperty
  a_txs_end: assert property (p_txs_end) else $error("status frame carries bytes after status");

  property p_loc_cmd;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && kind_r == frame_pkg::KIND_LOCAL && ofs_r == 5'h05) |-> fifo_in.data == cmd_r[15:8];
  endproperty
  a_loc_cmd: assert property (p_loc_cmd) else $error("local command character not at offset 5");

  property p_rem_len;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && kind_r == frame_pkg::KIND_REMOTE && ofs_r == 5'h02) |-> fifo_in.data == (8'h0d + {4'h0, plen_r});
  endproperty
  a_rem_len: assert property (p_rem_len) else $error("remote frame length wrong");

  property p_hold;
    @(posedge clk) disable iff (srst)
      (st_r == ST_EMIT && !fifo_in.ready && ce) |=> $stable(ofs_r);
  endproperty
  a_hold: assert property (p_hold) else $error("offset advanced while fifo full");
endmodule

// *** sim/host_sink.sv ***
// host-side sink model: paces the byte stream and verifies framing
`timescale 1ns/1ps
module host_sink (
  // clocking
  input wire logic clk,
  input wire logic srst,
  // byte stream from the builder
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  // pacing: 0 prompt, 1 slow, 2 stalled
  input wire logic [1:0] pace
);
  logic [7:0] rx_q[$];
  logic [7:0] sum = 8'h00;
  logic [7:0] byte_s = 8'h00;
  logic [1:0] ph = 2'h0;
  logic take = 1'b0;
  int cnt = 0;
  int len = 0;
  int csum_err = 0;
  initial out_ready = 1'b0;
  // decide the transfer at the falling edge so the rising edge never races the design
  always @(negedge clk) begin
    ph = ph + 2'h1;
    out_ready = (pace == 2'h0) || (pace == 2'h1 && ph == 2'h0);
    take = !srst && out_valid === 1'b1 && out_ready;
    byte_s = out_data;
  end
  // collect accepted bytes; a frame whose closing byte does not verify is kept and counted as a checksum error
  always @(posedge clk) begin
    if (srst) begin
      cnt = 0;
      sum = 8'h00;
    end else if (take) begin
      rx_q.push_back(byte_s);
      if (cnt == 1) len = byte_s * 256;
      if (cnt == 2) len = len + byte_s;
      if (cnt >= 3) sum = sum + byte_s;
      cnt = cnt + 1;
      if (cnt == len + 4) begin
        if (sum !== 8'hff) csum_err = csum_err + 1;
        cnt = 0;
        sum = 8'h00;
      end
    end
  end
endmodule

// *** sim/api_response_frame_builder_tb.sv ***
// testbench: response frame builder against a pacing host sink
`timescale 1ns/1ps
module api_response_frame_builder_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  frame_pkg::frame_kind_t req_kind = frame_pkg::KIND_TXSTAT;
  logic [7:0] req_frame_id = 8'h00;
  logic [31:0] req_ip_addr = 32'h0;
  logic [15:0] req_command = 16'h0;
  logic [7:0] req_status = 8'h00;
  logic [3:0] req_param_len = 4'h0;
  logic [63:0] req_param = 64'h0;
  logic [1:0] pace = 2'h0;
  logic req_ready, out_valid, out_ready, busy, suppressed;
  logic [7:0] out_data;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  api_response_frame_builder uut (.clk(clk), .srst(srst), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
    .req_kind(req_kind), .req_frame_id(req_frame_id), .req_ip_addr(req_ip_addr), .req_command(req_command),
    .req_status(req_status), .req_param_len(req_param_len), .req_param(req_param), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .busy(busy), .suppressed(suppressed));
  host_sink host (.clk(clk), .srst(srst), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .pace(pace));
  // ****************************************
  // shared helpers
  // ****************************************
  task check(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a hung handshake ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  // present one request, hold it until taken, then queue the bytes the host should see
  task send(frame_pkg::frame_kind_t k, logic [7:0] id, logic [31:0] ip, logic [15:0] cmd, logic [7:0] st,
            logic [3:0] pl, logic [63:0] pv);
    int n;
    logic [7:0] d[$];
    logic [7:0] s;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind = k;
    req_frame_id = id;
    req_ip_addr = ip;
    req_command = cmd;
    req_status = st;
    req_param_len = pl;
    req_param = pv;
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    if (k == frame_pkg::KIND_TXSTAT && id == frame_pkg::TX_ID_SUPPRESS) begin
      n = (suppressed === 1'b1);
      @(negedge clk);
      n += (suppressed === 1'b1);
      check("suppressed pulse", 8'h01, n[7:0]);
      return;
    end
    case (k)
      frame_pkg::KIND_REMOTE: d = {frame_pkg::TYPE_REMOTE_RSP, id, 8'h00, 8'h00, 8'h00, 8'h00,
        ip[31:24], ip[23:16], ip[15:8], ip[7:0], cmd[15:8], cmd[7:0], st};
      frame_pkg::KIND_LOCAL: d = {frame_pkg::TYPE_LOCAL_RSP, id, cmd[15:8], cmd[7:0], st};
      default: d = {frame_pkg::TYPE_TX_STATUS, id, st};
    endcase
    if (k != frame_pkg::KIND_TXSTAT)
      for (int i = 0; i < ((pl > 4'h8) ? 8 : pl); i++) d.push_back(pv[63 - 8 * i -: 8]);
    s = 8'h00;
    foreach (d[i]) s = s + d[i];
    exp_q = {exp_q, frame_pkg::START_DELIM, 8'h00, 8'(d.size()), d, 8'hff - s};
  endtask
  // wait for all queued bytes, then compare them one by one
  task drain();
    int n;
    n = 0;
    while (host.rx_q.size() < exp_q.size() && n < 3000) begin
      @(negedge clk);
      n++;
    end
    repeat (10) @(negedge clk);
    check("byte count", 8'(exp_q.size()), 8'(host.rx_q.size()));
    for (int i = 0; i < exp_q.size() && i < host.rx_q.size(); i++)
      check("frame byte", exp_q[i], host.rx_q[i]);
    check("checksum errors", 8'h00, 8'(host.csum_err));
    check("out_valid drained", 8'h00, {7'h0, out_valid});
    exp_q.delete();
    host.rx_q.delete();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset();
    check("req_ready", 8'h01, {7'h0, req_ready});
    check("out_valid", 8'h00, {7'h0, out_valid});
    check("busy", 8'h00, {7'h0, busy});
    check("suppressed", 8'h00, {7'h0, suppressed});
  endtask
  // every remote status code, with no value, short values, the full value and an over-long length
  task t_remote();
    logic [3:0] pls[5] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'hf};
    for (int s = 0; s < 5; s++)
      send(frame_pkg::KIND_REMOTE, 8'(s + 1), 32'hc0a80067, 16'h4431, 8'(s), pls[s], 64'h0123456789abcdef);
    drain();
  endtask
  // a setting write without value, then a burst of scan results back to back
  task t_local();
    send(frame_pkg::KIND_LOCAL, 8'h01, 32'h0, 16'h4244, frame_pkg::CMD_OK, 4'h0, 64'h0);
    for (int s = 0; s < 4; s++)
      send(frame_pkg::KIND_LOCAL, 8'h20, 32'h0, 16'h4153, 8'(s), 4'h8, 64'hfedcba9876543210 + s);
    drain();
  endtask
  // all delivery codes with a slow host; a zero id in the middle must yield no bytes
  task t_txstat();
    logic [7:0] codes[9] = '{8'h00, 8'h03, 8'h04, 8'h21, 8'h32, 8'h74, 8'h76, 8'h77, 8'h78};
    pace = 2'h1;
    for (int i = 0; i < 9; i++) begin
      send(frame_pkg::KIND_TXSTAT, 8'(i + 1), 32'h0, 16'h0, codes[i], 4'h3, 64'h0);
      if (i == 4) send(frame_pkg::KIND_TXSTAT, 8'h00, 32'h0, 16'h0, 8'h00, 4'h0, 64'h0);
    end
    drain();
    pace = 2'h0;
  endtask
  // a frame longer than the fifo while the host stalls; clock enable dropped meanwhile
  task t_stall();
    pace = 2'h2;
    send(frame_pkg::KIND_REMOTE, 8'h7f, 32'h0a000001, 16'h4e49, 8'h00, 4'h8, 64'h1122334455667788);
    repeat (40) @(negedge clk);
    check("busy while full", 8'h01, {7'h0, busy});
    check("req_ready while full", 8'h00, {7'h0, req_ready});
    check("nothing taken", 8'h00, 8'(host.rx_q.size()));
    ce = 1'b0;
    repeat (5) @(negedge clk);
    check("frozen busy", 8'h01, {7'h0, busy});
    ce = 1'b1;
    pace = 2'h0;
    drain();
  endtask
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_remote();
    t_local();
    t_txstat();
    t_stall();
    print_verdict();
  end
endmodule
